// File: pwmcdb_pkg.sv
package pwmcdb_pkg;
   // ************************************************************
   // Register map: word index is the byte address divided by four.
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;
   localparam int IDX_CH_BIT = 3;
   localparam logic [5:0] IDX_INHIBIT = 6'h10;
   localparam logic [2:0] SUB_CTRL = 3'h0;
   localparam logic [2:0] SUB_OE = 3'h1;
   localparam logic [2:0] SUB_POL = 3'h2;
   localparam logic [2:0] SUB_PER = 3'h3;
   localparam int SUB_BUF_BIT = 2;
   // ************************************************************
   // Fields and reset values.
   // ************************************************************
   localparam int CTRL_IE = 5;
   localparam int CTRL_CMF = 4;
   localparam int CTRL_CST = 3;
   localparam logic [7:0] CTRL_WMASK = 8'h2F;
   localparam logic [7:0] CTRL_RST = 8'hC0;
   localparam logic [15:0] PER_RST = 16'hFFFF;
   localparam logic [15:0] CNT_STOP = 16'hFC00;
   localparam int CNT_W = 10;
   localparam int DTY_SEL = 12;
   localparam logic [15:0] BUF_KEEP = 16'h13FF;
   localparam logic [15:0] BUF_RSV = 16'hEC00;
   localparam logic [9:0] CNT_ONE = 10'h001;
   // ************************************************************
   // Prescaler selections and bus response codes.
   // ************************************************************
   localparam int PS_W = 4;
   localparam logic [2:0] CKS_DIV1 = 3'h0;
   localparam logic [2:0] CKS_DIV2 = 3'h1;
   localparam logic [2:0] CKS_DIV4 = 3'h2;
   localparam logic [2:0] CKS_DIV8 = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: pwmcdb_prescale.sv
`timescale 1ns/1ps
module pwmcdb_prescale (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic run, // Counter running.
   input wire logic [2:0] cks, // Clock select field.
   output logic tick // One-cycle count enable.
);
   typedef struct packed {
      logic [pwmcdb_pkg::PS_W-1:0] div;
   } pwmcdb_ps_st_t;
   pwmcdb_ps_st_t st_reg;
   pwmcdb_ps_st_t st_next;

   // Restarting the divider with the counter gives a fixed first-tick delay.
   always_comb begin
      st_next = st_reg;
      st_next.div = run ? st_reg.div + 4'h1 : 4'h0;
      if (!aresetn) begin
         st_next.div = 4'h0;
      end
   end

   always_ff @(posedge aclk) begin
      st_reg <= st_next;
   end

   always_comb begin
      unique case (cks)
         pwmcdb_pkg::CKS_DIV1: tick = run;
         pwmcdb_pkg::CKS_DIV2: tick = run & (&st_reg.div[0:0]);
         pwmcdb_pkg::CKS_DIV4: tick = run & (&st_reg.div[1:0]);
         pwmcdb_pkg::CKS_DIV8: tick = run & (&st_reg.div[2:0]);
         default: tick = run & (&st_reg.div);
      endcase
   end
endmodule

// File: pwmcdb_outpair.sv
`timescale 1ns/1ps
module pwmcdb_outpair (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic run, // Counter running.
   input wire logic clr, // Period match pulse.
   input wire logic [15:0] duty, // Duty word in force next cycle.
   input wire logic [9:0] cnt, // Current counter value.
   input wire logic [1:0] pol, // Polarity bits of the pair.
   input wire logic [1:0] oe, // Output enables of the pair.
   output logic [1:0] pin // Pin levels, first then second.
);
   typedef struct packed {
      logic act;
      logic [1:0] pin;
   } pwmcdb_op_st_t;
   pwmcdb_op_st_t st_reg;
   pwmcdb_op_st_t st_next;
   logic sel;

   always_comb begin
      st_next = st_reg;
      sel = duty[pwmcdb_pkg::DTY_SEL];
      if (!run) begin
         st_next.act = 1'b0;
      end else if (clr) begin
         st_next.act = |duty[9:0];
      end else if (cnt == duty[9:0]) begin
         st_next.act = 1'b0;
      end
      st_next.pin[0] = oe[0] & ((st_next.act & ~sel) ^ pol[0]);
      st_next.pin[1] = oe[1] & ((st_next.act & sel) ^ pol[1]);
      if (!aresetn) begin
         st_next = '0;
      end
   end

   always_ff @(posedge aclk) begin
      st_reg <= st_next;
   end

   assign pin = st_reg.pin;
endmodule

// File: pwmcdb_top.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module pwmcdb_top (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [7:0] awaddr, // Write address.
   input wire logic awvalid, // Write address valid.
   output logic awready, // Write address ready.
   input wire logic [31:0] wdata, // Write data.
   input wire logic [3:0] wstrb, // Write byte strobes.
   input wire logic wvalid, // Write data valid.
   output logic wready, // Write data ready.
   output logic [1:0] bresp, // Write response.
   output logic bvalid, // Write response valid.
   input wire logic bready, // Write response ready.
   input wire logic [7:0] araddr, // Read address.
   input wire logic arvalid, // Read address valid.
   output logic arready, // Read address ready.
   output logic [31:0] rdata, // Read data.
   output logic [1:0] rresp, // Read response.
   output logic rvalid, // Read data valid.
   input wire logic rready, // Read data ready.
   output logic [15:0] pwm_out, // Pins A..H of channel 1, then channel 2.
   output logic [15:0] pwm_oe, // Pin output enables.
   output logic [1:0] match_irq // Period match requests per channel.
);
   // ************************************************************
   // State.
   // ************************************************************
   typedef struct packed {
      logic aw_got;
      logic [5:0] aw_idx;
      logic w_got;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0][7:0] ctrl;
      logic [1:0][7:0] oe;
      logic [1:0][7:0] pol;
      logic [1:0][15:0] per;
      logic [1:0][3:0][15:0] bufr;
      logic [1:0][3:0][15:0] dty;
      logic [1:0] seen;
      logic [7:0] inh;
      logic [1:0][9:0] cnt;
   } pwmcdb_top_st_t;
   pwmcdb_top_st_t st_reg;
   pwmcdb_top_st_t st_next;
   logic [1:0] run;
   logic [1:0] tick;
   logic [1:0] hit;
   logic [1:0] match;

   function automatic logic idx_ok(input logic [5:0] idx);
      idx_ok = (idx[5:4] == 2'h0) || (idx == pwmcdb_pkg::IDX_INHIBIT);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = old;
      if (s[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (s[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction

   // The upper six bits are the constant ones of the stopped value.
   function automatic logic per_eq(input logic [9:0] c, input logic [15:0] p);
      per_eq = {pwmcdb_pkg::CNT_STOP[15:pwmcdb_pkg::CNT_W], c} == p;
   endfunction

   // ************************************************************
   // Timebase per channel.
   // ************************************************************
   for (genvar c = 0; c < 2; c++) begin : g_ch
      assign run[c] = st_reg.ctrl[c][pwmcdb_pkg::CTRL_CST];
      assign hit[c] = per_eq(st_reg.cnt[c], st_reg.per[c]);
      assign match[c] = tick[c] & hit[c];
      assign match_irq[c] = st_reg.ctrl[c][pwmcdb_pkg::CTRL_CMF]
                            & st_reg.ctrl[c][pwmcdb_pkg::CTRL_IE];
      pwmcdb_prescale u_ps (
         .aclk(aclk),
         .aresetn(aresetn),
         .run(run[c]),
         .cks(st_reg.ctrl[c][2:0]),
         .tick(tick[c])
      );
      for (genvar k = 0; k < 4; k++) begin : g_pair
         pwmcdb_outpair u_op (
            .aclk(aclk),
            .aresetn(aresetn),
            .run(run[c]),
            .clr(match[c]),
            .duty(st_next.dty[c][k]),
            .cnt(st_reg.cnt[c]),
            .pol(st_reg.pol[c][2*k +: 2]),
            .oe(st_reg.oe[c][2*k +: 2]),
            .pin(pwm_out[8*c + 2*k +: 2])
         );
      end
   end

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      logic [5:0] ri;
      logic [5:0] wi;
      logic wc;
      logic rc;
      st_next = st_reg;
      ri = araddr[pwmcdb_pkg::IDX_LSB +: 6];
      wi = st_reg.aw_idx;
      wc = wi[pwmcdb_pkg::IDX_CH_BIT];
      rc = ri[pwmcdb_pkg::IDX_CH_BIT];
      if (st_reg.bvalid && bready) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.rvalid && rready) begin
         st_next.rvalid = 1'b0;
      end
      if (awvalid && !st_reg.aw_got) begin
         st_next.aw_got = 1'b1;
         st_next.aw_idx = awaddr[pwmcdb_pkg::IDX_LSB +: 6];
      end
      if (wvalid && !st_reg.w_got) begin
         st_next.w_got = 1'b1;
         st_next.wd = wdata;
         st_next.ws = wstrb;
      end
      // Register write once both halves are held; the counter has no address.
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = idx_ok(wi) ? pwmcdb_pkg::RESP_OKAY : pwmcdb_pkg::RESP_SLVERR;
         if (wi == pwmcdb_pkg::IDX_INHIBIT) begin
            if (st_reg.ws[0]) begin
               st_next.inh = st_reg.wd[7:0];
            end
         end else if (idx_ok(wi)) begin
            if (wi[pwmcdb_pkg::SUB_BUF_BIT]) begin
               st_next.bufr[wc][wi[1:0]] = merge16(st_reg.bufr[wc][wi[1:0]], st_reg.wd,
                  st_reg.ws) & pwmcdb_pkg::BUF_KEEP;
            end else begin
               unique case (wi[1:0])
                  pwmcdb_pkg::SUB_CTRL[1:0]: begin
                     if (st_reg.ws[0]) begin
                        st_next.ctrl[wc] = (st_reg.ctrl[wc] & ~pwmcdb_pkg::CTRL_WMASK)
                           | (st_reg.wd[7:0] & pwmcdb_pkg::CTRL_WMASK);
                        if (!st_reg.wd[pwmcdb_pkg::CTRL_CMF] && st_reg.seen[wc]) begin
                           st_next.ctrl[wc][pwmcdb_pkg::CTRL_CMF] = 1'b0;
                           st_next.seen[wc] = 1'b0;
                        end
                     end
                  end
                  pwmcdb_pkg::SUB_OE[1:0]: begin
                     if (st_reg.ws[0]) begin
                        st_next.oe[wc] = st_reg.wd[7:0];
                     end
                  end
                  pwmcdb_pkg::SUB_POL[1:0]: begin
                     if (st_reg.ws[0]) begin
                        st_next.pol[wc] = st_reg.wd[7:0];
                     end
                  end
                  pwmcdb_pkg::SUB_PER[1:0]: begin
                     st_next.per[wc] = merge16(st_reg.per[wc], st_reg.wd, st_reg.ws);
                  end
               endcase
            end
         end
      end
      if (arvalid && !st_reg.rvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = 32'h0000_0000;
         st_next.rresp = idx_ok(ri) ? pwmcdb_pkg::RESP_OKAY : pwmcdb_pkg::RESP_SLVERR;
         if (ri == pwmcdb_pkg::IDX_INHIBIT) begin
            st_next.rdata[7:0] = st_reg.inh;
         end else if (!idx_ok(ri)) begin
            st_next.rdata = 32'h0000_0000;
         end else if (ri[pwmcdb_pkg::SUB_BUF_BIT]) begin
            st_next.rdata[15:0] = st_reg.bufr[rc][ri[1:0]] | pwmcdb_pkg::BUF_RSV;
         end else begin
            unique case (ri[1:0])
               pwmcdb_pkg::SUB_CTRL[1:0]: begin
                  st_next.rdata[7:0] = st_reg.ctrl[rc];
                  if (st_reg.ctrl[rc][pwmcdb_pkg::CTRL_CMF]) begin
                     st_next.seen[rc] = 1'b1;
                  end
               end
               pwmcdb_pkg::SUB_OE[1:0]: st_next.rdata[7:0] = st_reg.oe[rc];
               pwmcdb_pkg::SUB_POL[1:0]: st_next.rdata[7:0] = st_reg.pol[rc];
               pwmcdb_pkg::SUB_PER[1:0]: st_next.rdata[15:0] = st_reg.per[rc];
            endcase
         end
      end
      // Hardware updates follow software so that a match beats a flag clear.
      for (int c = 0; c < 2; c++) begin
         if (!run[c]) begin
            st_next.cnt[c] = pwmcdb_pkg::CNT_STOP[9:0];
         end else if (match[c]) begin
            st_next.cnt[c] = 10'h000;
         end else if (tick[c]) begin
            st_next.cnt[c] = st_reg.cnt[c] + pwmcdb_pkg::CNT_ONE;
         end
         if (match[c]) begin
            st_next.ctrl[c][pwmcdb_pkg::CTRL_CMF] = 1'b1;
            for (int k = 0; k < 4; k++) begin
               if (!st_reg.inh[4*c + k]) begin
                  st_next.dty[c][k] = st_reg.bufr[c][k];
               end
            end
         end
      end
      if (!aresetn) begin
         st_next = '0;
         for (int c = 0; c < 2; c++) begin
            st_next.ctrl[c] = pwmcdb_pkg::CTRL_RST;
            st_next.per[c] = pwmcdb_pkg::PER_RST;
            st_next.cnt[c] = pwmcdb_pkg::CNT_STOP[9:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      st_reg <= st_next;
   end

   assign awready = !st_reg.aw_got;
   assign wready = !st_reg.w_got;
   assign bvalid = st_reg.bvalid;
   assign bresp = st_reg.bresp;
   assign arready = !st_reg.rvalid;
   assign rvalid = st_reg.rvalid;
   assign rdata = st_reg.rdata;
   assign rresp = st_reg.rresp;
   assign pwm_oe = {st_reg.oe[1], st_reg.oe[0]};

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_cnt_step: assert property (run[0] && tick[0] && !hit[0] |=>
      st_reg.cnt[0] == 10'($past(st_reg.cnt[0]) + 10'h001))
      else $error("counter did not step on tick");
   a_cnt_stopped: assert property (!run[1] |=> st_reg.cnt[1] == 10'h000)
      else $error("stopped counter not at its initial value");
   a_match_clear: assert property (match[0] |=> st_reg.cnt[0] == 10'h000 &&
      st_reg.ctrl[0][4])
      else $error("period match did not clear counter or set flag");
   a_copy_duty: assert property (match[0] && !st_reg.inh[1] |=>
      st_reg.dty[0][1] == $past(st_reg.bufr[0][1]))
      else $error("buffer not copied on period match");
   a_copy_block: assert property (match[1] && st_reg.inh[4] |=>
      $stable(st_reg.dty[1][0]))
      else $error("inhibited duty register changed");
   a_reset_per: assert property ($past(!aresetn) |-> st_reg.per[0] == 16'hFFFF)
      else $error("period register reset value wrong");
   a_buf_rsv: assert property (st_reg.rvalid && $past(arvalid && araddr == 8'h10 &&
      !st_reg.rvalid) |-> st_reg.rdata[15:13] == 3'h7 && st_reg.rdata[11:10] == 2'h3)
      else $error("buffer reserved bits not read as one");
   a_stop_level: assert property (!run[0] |=> pwm_out[0] == $past(st_reg.oe[0][0] &
      st_reg.pol[0][0]))
      else $error("stopped output not at inactive level");
   a_oe_off: assert property (!st_reg.oe[1][7] |=> !pwm_out[15])
      else $error("disabled pin drives high");
   a_zero_duty: assert property (st_reg.dty[0][0][9:0] == 10'h000 && !match[0] &&
      $past(st_reg.dty[0][0][9:0] == 10'h000) && !st_reg.pol[0][0] |=> !pwm_out[0])
      else $error("zero duty produced active level");
   a_flag_hold: assert property (st_reg.ctrl[0][4] && !st_reg.seen[0] |=>
      st_reg.ctrl[0][4])
      else $error("flag cleared without prior read");

   c_match: cover property (match[0] && st_reg.ctrl[0][2:0] != 3'h0);
   c_flag_clear: cover property ($fell(st_reg.ctrl[0][4]));
   c_write_resp: cover property (bvalid && bready && bresp == 2'h0);
   c_pin_b: cover property (run[0] && pwm_out[1]);
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, match_irq;
   logic [15:0] pwm_out, pwm_oe;
   int n_fail, comparisons;
   localparam logic [1:0] OK = pwmcdb_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = pwmcdb_pkg::RESP_SLVERR;
   localparam logic [31:0] BRST = {16'h0, pwmcdb_pkg::BUF_RSV};

   pwmcdb_top i_pwmcdb_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe), .match_irq(match_irq));

   // ****************************************************************
   // Checking and bus tasks.
   // ****************************************************************
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   // Ready signals of the answer channels stay high, so no strobe is driven twice per step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!done && n < 100) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            done = 1'h1;
            chk({30'h0, bresp}, {30'h0, er}, "write response");
         end
      end
      chk_n(int'(done), 1, "write answered");
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      while (!done && n < 100) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) begin
            done = 1'h1;
            chk(rdata, ed, "read data");
            chk({30'h0, rresp}, {30'h0, er}, "read response");
         end
      end
      chk_n(int'(done), 1, "read answered");
   endtask

   // Measures one frame from the start of the active level: active and total cycles.
   task automatic frame(input int b, input logic lvl, output int act, output int tot);
      int n;
      n = 0;
      act = 0;
      while (pwm_out[b] === lvl && n < 600) begin
         @(posedge aclk);
         n++;
      end
      while (pwm_out[b] !== lvl && n < 600) begin
         @(posedge aclk);
         n++;
      end
      while (pwm_out[b] === lvl && n < 600) begin
         @(posedge aclk);
         n++;
         act++;
      end
      tot = act;
      while (pwm_out[b] !== lvl && n < 600) begin
         @(posedge aclk);
         n++;
         tot++;
      end
      chk_n(int'(n < 600), 1, "waveform present");
   endtask

   task automatic hold_chk(input int b, input logic lvl, input int cyc);
      int bad;
      bad = 0;
      repeat (cyc) begin
         @(posedge aclk);
         if (pwm_out[b] !== lvl) bad++;
      end
      chk_n(bad, 0, "pin left its steady level");
   endtask

   // ****************************************************************
   // Scenarios. Channel 1 runs a ten-count frame with period FC09.
   // ****************************************************************
   task automatic t_reset_values();
      rd(8'h0C, {16'h0, pwmcdb_pkg::PER_RST}, OK);
      rd(8'h10, BRST, OK);
      rd(8'h3C, BRST, OK);
      rd(8'h40, 32'h0, OK);
      rd(8'h44, 32'h0, ERR);
      wr(8'h44, 32'hFFFF, ERR);
      chk({16'h0, pwm_oe}, 32'h0, "enables after reset");
   endtask

   task automatic t_buffer_bits();
      wr(8'h14, 32'hFFFF, OK);
      rd(8'h14, 32'hFFFF, OK);
      wr(8'h14, 32'h0, OK);
      rd(8'h14, BRST, OK);
      wr(8'h40, 32'hA5, OK);
      rd(8'h40, 32'hA5, OK);
      wr(8'h40, 32'h0, OK);
   endtask

   task automatic t_waveform();
      int act, tot;
      wr(8'h04, 32'hFF, OK);
      wr(8'h0C, 32'hFC09, OK);
      rd(8'h0C, 32'hFC09, OK);
      wr(8'h10, 32'h0003, OK);
      wr(8'h00, 32'h08, OK);
      frame(0, 1'h1, act, tot);
      chk_n(act, 4, "active cycles");
      chk_n(tot, 10, "frame length");
      hold_chk(1, 1'h0, 20);
      chk({16'h0, pwm_oe}, 32'hFF, "pin enables");
   endtask

   task automatic t_prescale();
      int act, tot;
      logic [2:0] cks [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
      int div [5] = '{1, 2, 4, 8, 16};
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, 32'h00, OK);
         wr(8'h00, {28'h0, 1'h1, cks[i]}, OK);
         frame(0, 1'h1, act, tot);
         chk_n(tot, 10 * div[i], "prescaled frame");
      end
      wr(8'h00, 32'h08, OK);
   endtask

   task automatic t_select_pol();
      int act, tot;
      wr(8'h08, 32'h03, OK);
      wr(8'h10, 32'h1003, OK);
      frame(1, 1'h0, act, tot);
      chk_n(act, 4, "inverted active cycles");
      hold_chk(0, 1'h1, 20);
      wr(8'h08, 32'h00, OK);
      wr(8'h10, 32'h0000, OK);
      repeat (25) @(posedge aclk);
      hold_chk(0, 1'h0, 30);
   endtask

   task automatic t_inhibit();
      int act, tot;
      wr(8'h40, 32'h10, OK);
      wr(8'h10, 32'h0006, OK);
      frame(0, 1'h1, act, tot);
      chk_n(act, 7, "copy with other bit set");
      wr(8'h40, 32'h01, OK);
      wr(8'h10, 32'h0002, OK);
      repeat (25) @(posedge aclk);
      frame(0, 1'h1, act, tot);
      chk_n(act, 7, "copy blocked");
      wr(8'h40, 32'h00, OK);
      frame(0, 1'h1, act, tot);
      frame(0, 1'h1, act, tot);
      chk_n(act, 3, "copy resumed");
   endtask

   // Channel 2 runs its own ten-count frame while channel 1 keeps running.
   task automatic t_channel2();
      int act, tot;
      wr(8'h24, 32'hFF, OK);
      wr(8'h2C, 32'hFC09, OK);
      wr(8'h30, 32'h0003, OK);
      wr(8'h20, 32'h08, OK);
      frame(8, 1'h1, act, tot);
      chk_n(act, 4, "channel 2 active cycles");
      chk_n(tot, 10, "channel 2 frame length");
      wr(8'h40, 32'h10, OK);
      wr(8'h30, 32'h0006, OK);
      repeat (25) @(posedge aclk);
      frame(8, 1'h1, act, tot);
      chk_n(act, 4, "channel 2 copy blocked");
      wr(8'h40, 32'h00, OK);
      wr(8'h20, 32'h00, OK);
      hold_chk(8, 1'h0, 20);
   endtask

   task automatic t_flag_stop();
      wr(8'h00, 32'h28, OK);
      repeat (12) @(posedge aclk);
      chk({30'h0, match_irq}, 32'h1, "match request");
      wr(8'h08, 32'h0F, OK);
      wr(8'h00, 32'h30, OK);
      repeat (3) @(posedge aclk);
      chk({24'h0, pwm_out[7:0]}, 32'h0F, "stopped levels");
      hold_chk(0, 1'h1, 30);
      rd(8'h00, 32'hF0, OK);
      wr(8'h00, 32'h20, OK);
      rd(8'h00, 32'hE0, OK);
      chk({30'h0, match_irq}, 32'h0, "request cleared");
   endtask

   // ****************************************************************
   // Clock, reset, sequence and watchdog.
   // ****************************************************************
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      n_fail = 0;
      comparisons = 0;
      aresetn = 1'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hF;
      awvalid = 1'h0;
      wvalid = 1'h0;
      arvalid = 1'h0;
      bready = 1'h1;
      rready = 1'h1;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset_values();
      t_buffer_bits();
      t_waveform();
      t_prescale();
      t_select_pol();
      t_inhibit();
      t_channel2();
      t_flag_stop();
      test_done();
   end

   // The whole sequence needs somewhat over a thousand cycles; this bound leaves wide room.
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done();
   end
endmodule
